// *** core/pmi_pkg.sv ***
// Purpose: constants for the pulse match interrupt and wake-up block
// Assumes: one clock REF_CLK at 40 MHz, synchronous active-high reset
// Notes:   no register bus; every control and status bit is a port
package pmi_pkg;
    localparam int unsigned PC_W        = 13;
    localparam int unsigned STACK_DEPTH = 8;
    localparam int unsigned SP_W        = 4;
    localparam int unsigned GRP_N       = 4;
    localparam logic [PC_W-1:0] VECTOR_ADDR = 13'h0_010;
    localparam logic [SP_W-1:0] SP_EMPTY    = 4'h0;
    localparam logic [SP_W-1:0] SP_FULL     = 4'h8;
    localparam logic [SP_W-1:0] SP_ONE      = 4'h1;
    localparam logic [PC_W-1:0] PC_RESET    = 13'h0_000;
    typedef enum logic [1:0] {PMI_RUN, PMI_LOW_POWER} pmi_mode_e;
endpackage

// *** core/pmi_stack.sv ***
`timescale 1ns/1ps
// Purpose: return-address stack for the interrupt entry
// Assumes: push and pop never both asserted in one cycle
// Notes:   push on full and pop on empty are ignored
module pmi_stack
    import pmi_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            srst,
    input  wire logic            push,
    input  wire logic            pop,
    input  wire logic [PC_W-1:0] push_data,
    output logic      [PC_W-1:0] top_data,
    output logic                 full,
    output logic                 empty
);
    logic [PC_W-1:0] mem_q [STACK_DEPTH];
    logic [PC_W-1:0] mem_d [STACK_DEPTH];
    logic [SP_W-1:0] sp_q;
    logic [SP_W-1:0] sp_d;

    assign full  = (sp_q == SP_FULL);
    assign empty = (sp_q == SP_EMPTY);

    always_comb begin
        sp_d = sp_q;
        for (int i = 0; i < STACK_DEPTH; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (push && !full) begin
            mem_d[sp_q[SP_W-2:0]] = push_data;
            sp_d = sp_q + SP_ONE;
        end else if (pop && !empty) begin
            sp_d = sp_q - SP_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sp_q <= SP_EMPTY;
        end else begin
            sp_q <= sp_d;
        end
    end

    generate
        for (genvar g = 0; g < STACK_DEPTH; g++) begin : g_mem
            always_ff @(posedge clk) begin
                if (srst) begin
                    mem_q[g] <= PC_RESET;
                end else begin
                    mem_q[g] <= mem_d[g];
                end
            end
        end
    endgenerate

    always_comb begin
        top_data = PC_RESET;
        if (!empty) begin
            top_data = mem_q[3'(sp_q - SP_ONE)];
        end
    end
endmodule // pmi_stack

// *** core/pmi_ctrl.sv ***
`timescale 1ns/1ps
// Purpose: match-done source, combined request, vectoring, wake and return
// Assumes: cpu pulses the op strobes once per op and flags instruction ends
// Notes:   wake works with no oscillator only in silicon; here it is clocked
module pmi_ctrl
    import pmi_pkg::*;
(
    input  wire logic             REF_CLK,
    input  wire logic             SRST,
    input  wire logic             MATCH_C_DONE,
    input  wire logic             MATCH_D_DONE,
    input  wire logic [GRP_N-2:0] OTHER_SRC_SET,
    input  wire logic             MATCH_DONE_ENABLE,
    input  wire logic             COMBINED_ENABLE,
    input  wire logic             MATCH_FLAG_SW_SET,
    input  wire logic             MATCH_FLAG_SW_CLR,
    input  wire logic             GLOBAL_EN_SW_SET,
    input  wire logic             GLOBAL_EN_SW_CLR,
    input  wire logic             COMBINED_FLAG_SW_CLR,
    input  wire logic             INSTR_BOUNDARY,
    input  wire logic [PC_W-1:0]  RETURN_PC,
    input  wire logic             RETURN_FROM_IRQ_OP,
    input  wire logic             PLAIN_RETURN_OP,
    input  wire logic             ENTER_LOW_POWER,
    output logic                  MATCH_DONE_FLAG,
    output logic                  COMBINED_IRQ_FLAG,
    output logic                  GLOBAL_IRQ_ENABLE,
    output logic                  VECTOR_CALL,
    output logic      [PC_W-1:0]  NEXT_PC,
    output logic                  NEXT_PC_VALID,
    output logic                  LOW_POWER,
    output logic                  WAKE_UP,
    output logic                  STACK_FULL
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic            match_q, match_d;
    logic            comb_q, comb_d;
    logic            gie_q, gie_d;
    logic            wake_q, wake_d;
    logic            vcall_q, vcall_d;
    logic            npv_q, npv_d;
    logic [PC_W-1:0] npc_q, npc_d;
    pmi_mode_e       mode_q, mode_d;
    logic            match_rise;
    logic            comb_rise;
    logic            take;
    logic            any_ret;
    logic            st_full;
    logic            st_empty;
    logic [PC_W-1:0] st_top;

    pmi_stack u_stack (
        .clk       (REF_CLK),
        .srst      (SRST),
        .push      (take),
        .pop       (any_ret),
        .push_data (RETURN_PC),
        .top_data  (st_top),
        .full      (st_full),
        .empty     (st_empty)
    );

    // ------------------------------------------------------------
    // flags and vectoring
    // ------------------------------------------------------------
    // only the pc goes on the stack; cpu saves the rest in software
    assign take = INSTR_BOUNDARY && gie_q && MATCH_DONE_ENABLE
                  && COMBINED_ENABLE && comb_q && match_q && !st_full;
    assign any_ret = (RETURN_FROM_IRQ_OP || PLAIN_RETURN_OP) && !st_empty;

    always_comb begin
        match_d = match_q;
        if (MATCH_FLAG_SW_CLR) begin
            match_d = 1'b0;
        end
        // set wins over a clear in the same cycle; service never clears
        if (MATCH_C_DONE || MATCH_D_DONE || MATCH_FLAG_SW_SET) begin
            match_d = 1'b1;
        end
        match_rise = match_d && !match_q;
        comb_d = comb_q;
        if (COMBINED_FLAG_SW_CLR || take) begin
            comb_d = 1'b0;
        end
        if (match_rise || (|OTHER_SRC_SET)) begin
            comb_d = 1'b1;
        end
        comb_rise = comb_d && !comb_q;
        gie_d = gie_q;
        if (GLOBAL_EN_SW_CLR || take) begin
            gie_d = 1'b0;
        end
        if (GLOBAL_EN_SW_SET || (RETURN_FROM_IRQ_OP && any_ret)) begin
            gie_d = 1'b1;
        end
        // plain return leaves gie_d alone
        vcall_d = take;
        npv_d   = take || any_ret;
        npc_d   = npc_q;
        if (take) begin
            npc_d = VECTOR_ADDR;
        end else if (any_ret) begin
            npc_d = st_top;
        end
    end

    // ------------------------------------------------------------
    // low power and wake
    // ------------------------------------------------------------
    // a flag already high cannot rise, so it cannot wake us
    always_comb begin
        mode_d = mode_q;
        wake_d = 1'b0;
        case (mode_q)
            PMI_RUN: begin
                if (ENTER_LOW_POWER) begin
                    mode_d = PMI_LOW_POWER;
                end
            end
            PMI_LOW_POWER: begin
                if (match_rise || comb_rise) begin
                    mode_d = PMI_RUN;
                    wake_d = 1'b1;
                end
            end
            default: begin
                mode_d = PMI_RUN;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            match_q <= 1'b0;
            comb_q  <= 1'b0;
            gie_q   <= 1'b0;
            wake_q  <= 1'b0;
            vcall_q <= 1'b0;
            npv_q   <= 1'b0;
            npc_q   <= PC_RESET;
            mode_q  <= PMI_RUN;
        end else begin
            match_q <= match_d;
            comb_q  <= comb_d;
            gie_q   <= gie_d;
            wake_q  <= wake_d;
            vcall_q <= vcall_d;
            npv_q   <= npv_d;
            npc_q   <= npc_d;
            mode_q  <= mode_d;
        end
    end

    assign MATCH_DONE_FLAG   = match_q;
    assign COMBINED_IRQ_FLAG = comb_q;
    assign GLOBAL_IRQ_ENABLE = gie_q;
    assign VECTOR_CALL       = vcall_q;
    assign NEXT_PC           = npc_q;
    assign NEXT_PC_VALID     = npv_q;
    assign LOW_POWER         = (mode_q == PMI_LOW_POWER);
    assign WAKE_UP           = wake_q;
    assign STACK_FULL        = st_full;
endmodule // pmi_ctrl

// *** tb/pmi_ctrl_properties.sv ***
// Purpose: port-level checks on pmi_ctrl
// Assumes: inputs change away from the rising edge
// Notes:   bound onto every pmi_ctrl instance
`timescale 1ns/1ps
module pmi_props
    import pmi_pkg::*;
(
    input wire logic            REF_CLK,
    input wire logic            SRST,
    input wire logic            MATCH_C_DONE,
    input wire logic            MATCH_D_DONE,
    input wire logic            MATCH_DONE_ENABLE,
    input wire logic            COMBINED_ENABLE,
    input wire logic            MATCH_FLAG_SW_CLR,
    input wire logic            GLOBAL_EN_SW_SET,
    input wire logic            INSTR_BOUNDARY,
    input wire logic            RETURN_FROM_IRQ_OP,
    input wire logic            PLAIN_RETURN_OP,
    input wire logic            MATCH_DONE_FLAG,
    input wire logic            COMBINED_IRQ_FLAG,
    input wire logic            GLOBAL_IRQ_ENABLE,
    input wire logic            VECTOR_CALL,
    input wire logic [PC_W-1:0] NEXT_PC,
    input wire logic            NEXT_PC_VALID,
    input wire logic            LOW_POWER,
    input wire logic            WAKE_UP,
    input wire logic            STACK_FULL
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    chk_match_sets: assert property (
        (MATCH_C_DONE || MATCH_D_DONE) |=> MATCH_DONE_FLAG) else $error("no set");
    chk_vector_gate: assert property (VECTOR_CALL |->
        $past(GLOBAL_IRQ_ENABLE && MATCH_DONE_ENABLE && COMBINED_ENABLE &&
        COMBINED_IRQ_FLAG && INSTR_BOUNDARY && !STACK_FULL))
        else $error("vector without cause");
    chk_service_clears: assert property (
        VECTOR_CALL |-> !GLOBAL_IRQ_ENABLE && !COMBINED_IRQ_FLAG)
        else $error("service left enable or flag");
    chk_flag_holds: assert property (
        MATCH_DONE_FLAG && !MATCH_FLAG_SW_CLR |=> MATCH_DONE_FLAG)
        else $error("flag dropped");
    chk_wake_rise: assert property (
        $rose(MATCH_DONE_FLAG) && $past(LOW_POWER) |-> ##[0:1] WAKE_UP)
        else $error("no wake");
    chk_vector_addr: assert property (
        VECTOR_CALL |-> NEXT_PC_VALID && NEXT_PC == VECTOR_ADDR)
        else $error("bad vector");
    chk_enable_cause: assert property ($rose(GLOBAL_IRQ_ENABLE) |->
        $past(RETURN_FROM_IRQ_OP || GLOBAL_EN_SW_SET))
        else $error("enable rose alone");
    chk_plain_keeps: assert property (PLAIN_RETURN_OP &&
        !GLOBAL_IRQ_ENABLE && !GLOBAL_EN_SW_SET |=> !GLOBAL_IRQ_ENABLE)
        else $error("plain return enabled");
    // group flag rises on the same edge; a take may clear it one edge later
    chk_group_sets: assert property (
        $rose(MATCH_DONE_FLAG) |-> COMBINED_IRQ_FLAG) else $error("no group");
endmodule // pmi_props
bind pmi_ctrl pmi_props pmi_props_inst (.*);

// *** tb/pmi_ctrl_test.sv ***
// Purpose: directed tests of pmi_ctrl
// Assumes: ops are one-cycle pulses driven on the falling edge
// Notes:   tb nets mirror the port names so the instance binds by name
`timescale 1ns/1ps
module pmi_ctrl_test
    import pmi_pkg::*;
;
    localparam int CD = 0, DD = 1, FS = 2, FC = 3, GS = 4, RI = 5, PR = 6;
    localparam int LP = 7, OS = 8, CC = 9;
    logic            REF_CLK = 1'b0, SRST = 1'b1, INSTR_BOUNDARY = 1'b0;
    logic            MATCH_DONE_ENABLE = 1'b0, COMBINED_ENABLE = 1'b1;
    logic [PC_W-1:0] RETURN_PC = 13'h0_000, NEXT_PC;
    logic [9:0]      ops = 10'h000;
    logic            MATCH_DONE_FLAG, COMBINED_IRQ_FLAG, GLOBAL_IRQ_ENABLE;
    logic            VECTOR_CALL, NEXT_PC_VALID, LOW_POWER, WAKE_UP, STACK_FULL;
    wire logic       MATCH_C_DONE, MATCH_D_DONE, MATCH_FLAG_SW_SET;
    wire logic       MATCH_FLAG_SW_CLR, GLOBAL_EN_SW_SET, RETURN_FROM_IRQ_OP;
    wire logic       PLAIN_RETURN_OP, ENTER_LOW_POWER, COMBINED_FLAG_SW_CLR;
    wire logic [2:0] OTHER_SRC_SET;
    wire logic       GLOBAL_EN_SW_CLR = 1'b0;
    int              error_cnt = 0, n_checks = 0;
    assign {COMBINED_FLAG_SW_CLR, OTHER_SRC_SET[0], ENTER_LOW_POWER,
            PLAIN_RETURN_OP, RETURN_FROM_IRQ_OP, GLOBAL_EN_SW_SET,
            MATCH_FLAG_SW_CLR, MATCH_FLAG_SW_SET, MATCH_D_DONE,
            MATCH_C_DONE} = ops;
    assign OTHER_SRC_SET[2:1] = 2'h0;
    always #12.5 REF_CLK = ~REF_CLK;
    pmi_ctrl pmi_ctrl_inst (.*);
    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task automatic step(int n = 1);
        repeat (n) @(negedge REF_CLK);
    endtask
    // leading step keeps a clear and the next set in separate time steps
    task automatic pulse(int sel);
        step();
        ops[sel] = 1'b1;
        step();
        ops[sel] = 1'b0;
    endtask
    task automatic wait_pulse(int sel, output logic got);
        got = 1'b0;
        for (int i = 0; i < 10 && got !== 1'b1; i++) begin
            got = sel == 0 ? VECTOR_CALL : sel == 1 ? NEXT_PC_VALID : WAKE_UP;
            if (got !== 1'b1) step();
        end
    endtask
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        #50us;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        logic got;
        step(12);
        SRST = 1'b0;
        check({MATCH_DONE_FLAG, GLOBAL_IRQ_ENABLE, LOW_POWER}, 3'h0);
        {MATCH_DONE_ENABLE, INSTR_BOUNDARY, RETURN_PC} = {2'h3, 13'h0_123};
        pulse(GS);
        pulse(CD);
        wait_pulse(0, got);
        check({got, NEXT_PC}, {1'b1, VECTOR_ADDR});
        check({GLOBAL_IRQ_ENABLE, COMBINED_IRQ_FLAG, MATCH_DONE_FLAG}, 3'h1);
        RETURN_PC = 13'h0_456;
        pulse(RI);
        wait_pulse(1, got);
        check({got, NEXT_PC, GLOBAL_IRQ_ENABLE}, {1'b1, 13'h0_123, 1'b1});
        pulse(FC);
        check(MATCH_DONE_FLAG, 1'b0);
        $display("test service done");
        MATCH_DONE_ENABLE = 1'b0;
        pulse(DD);
        wait_pulse(0, got);
        check({got, MATCH_DONE_FLAG}, 2'h1);
        {MATCH_DONE_ENABLE, INSTR_BOUNDARY} = 2'h2;
        wait_pulse(0, got);
        check(got, 1'b0);
        {INSTR_BOUNDARY, COMBINED_ENABLE} = 2'h2;
        wait_pulse(0, got);
        check(got, 1'b0);
        COMBINED_ENABLE = 1'b1;
        wait_pulse(0, got);
        check(got, 1'b1);
        // handler makes no nested call before its return
        pulse(PR);
        wait_pulse(1, got);
        check({got, NEXT_PC, GLOBAL_IRQ_ENABLE}, {1'b1, 13'h0_456, 1'b0});
        $display("test gating done");
        MATCH_DONE_ENABLE = 1'b0;
        pulse(FS);
        step(2);
        pulse(LP);
        pulse(CD);
        wait_pulse(2, got);
        check({got, LOW_POWER}, 2'h1);
        pulse(FC);
        pulse(DD);
        wait_pulse(2, got);
        step(2);
        check({got, LOW_POWER}, 2'h2);
        $display("test wake done");
        MATCH_DONE_ENABLE = 1'b1;
        for (int i = 0; i < 9; i++) begin
            RETURN_PC = 13'(i);
            pulse(OS);
            pulse(GS);
            wait_pulse(0, got);
            check({got, STACK_FULL}, {i < 8, i > 6});
        end
        pulse(CC);
        for (int i = 7; i >= 0; i--) begin
            pulse(RI);
            wait_pulse(1, got);
            check({got, NEXT_PC}, {1'b1, 13'(i)});
        end
        $display("test stack done");
        tally_and_finish();
    end
endmodule // pmi_ctrl_test
